// File: dv/hub_rx_mode_rate_config_props.sv
`timescale 1ns/1ps
module hub_props
  import hub_mode_pkg::*;
(
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // headers
  input wire logic hdr_in_valid,
  input wire logic hdr_out_valid,
  // config
  input wire logic strap_done,
  input wire logic [2:0] mode_strap,
  input wire rx_mode_type rx_mode,
  input wire logic [5:0] frame_bits,
  input wire logic [2:0] back_channel_rate,
  input wire rate_type line_rate,
  input wire logic [3:0] pixel_bits
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // outputs lag the mode by a cycle, so only judge a settled mode
  sequence settled;
    $past(strap_done, 3) && $stable(rx_mode);
  endsequence
  frame_len_a: assert property (
    settled |-> frame_bits == (rx_mode == MODE_PACKET ? FRAME_PACKET : FRAME_RAW)) else $error("frame length wrong");
  raw_bc_a: assert property (
    settled ##0 rx_mode != MODE_PACKET |-> back_channel_rate == BC_2M5) else $error("raw back channel wrong");
  sync_rate_a: assert property (
    settled ##0 ($stable(back_channel_rate) && rx_mode == MODE_PACKET && back_channel_rate == BC_50M)
    |-> line_rate == {SRC_REF, 8'hA0, 2'h1, 3'h4, 2'h1}) else $error("sync rate wrong");
  raw10_rate_a: assert property (
    settled ##0 rx_mode == MODE_RAW10 |-> line_rate == {SRC_PIXEL, 8'h0E, 2'h1, 3'h1, 2'h2}) else $error("raw10 rate");
  raw10_pix_a: assert property (
    settled ##0 rx_mode == MODE_RAW10 |-> pixel_bits inside {PIX_8, PIX_10}) else $error("raw10 pixel width");
  strap_mode_a: assert property (
    $rose(strap_done) |-> ##[0:2] rx_mode == rx_mode_type'(mode_strap[1:0])) else $error("strap mode wrong");
  hdr_pass_a: assert property (
    ce && strap_done && hdr_in_valid |=> hdr_out_valid) else $error("header lost");
  hdr_block_a: assert property (
    !strap_done |-> !hdr_out_valid) else $error("header before strap");
  read_ans_a: assert property (
    ce && arvalid && arready |=> rvalid) else $error("read answer late");
  cover property ($rose(strap_done));
  cover property (hdr_out_valid);
  cover property (rx_mode == MODE_RAW12_HIGH_FREQ);
endmodule

bind hub_rx_mode_rate_config hub_props u_hub_props (.aclk, .aresetn, .ce, .arvalid, .arready, .rvalid,
  .hdr_in_valid, .hdr_out_valid, .strap_done, .mode_strap, .rx_mode, .frame_bits, .back_channel_rate,
  .line_rate, .pixel_bits);

// File: dv/serializer_model.sv
`timescale 1ns/1ps
module serializer_model
  import hub_mode_pkg::*;
(
  // clock
  input wire logic aclk,
  // link side
  output logic recovered_parallel_clock,
  output hdr_type hdr_in,
  output logic hdr_in_valid
);
  // free running own clock, phase unrelated to aclk
  initial begin
    recovered_parallel_clock = 1'b0;
    #7;
    forever #24 recovered_parallel_clock = ~recovered_parallel_clock;
  end
  initial begin
    hdr_in = '0;
    hdr_in_valid = 1'b0;
  end
  // one header per call; no sync lines, so no toggle spacing to break
  task automatic send(input hdr_type h);
    @(posedge aclk);
    hdr_in <= h;
    hdr_in_valid <= 1'b1;
    @(posedge aclk);
    hdr_in <= ~h;
    hdr_in_valid <= 1'b0;
  endtask
endmodule

// File: dv/test_hub_rx_mode_rate_config.sv
`timescale 1ns/1ps
module test_hub_rx_mode_rate_config;
  import hub_mode_pkg::*;
  logic aclk, aresetn, ce, ref_clock_in, recovered_parallel_clock, hdr_in_valid, hdr_out_valid, strap_done;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, pixel_bits;
  logic [1:0] bresp, rresp, lane_count;
  logic [2:0] mode_strap, back_channel_rate;
  logic [5:0] frame_bits;
  hdr_type hdr_in, hdr_out;
  rx_mode_type rx_mode;
  rate_type line_rate;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] ln [3] = '{8'h1C, 8'h38, 8'h0E};
  logic [1:0] ld [3] = '{2'h1, 2'h3, 2'h1};
  logic [2:0] pn [3] = '{3'h1, 3'h2, 3'h1};
  logic [1:0] pd [3] = '{2'h1, 2'h3, 2'h2};
  logic [3:0] px [3] = '{PIX_12, PIX_12, PIX_10};

  hub_rx_mode_rate_config u_hub_rx_mode_rate_config (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .mode_strap, .ref_clock_in, .recovered_parallel_clock, .hdr_in,
    .hdr_in_valid, .hdr_out, .hdr_out_valid, .rx_mode, .strap_done, .frame_bits, .back_channel_rate,
    .line_rate, .pixel_bits, .lane_count);
  serializer_model u_serializer_model (.aclk, .recovered_parallel_clock, .hdr_in, .hdr_in_valid);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    ref_clock_in = 1'b0;
    #3;
    forever #20 ref_clock_in = ~ref_clock_in;
  end

  // ************
  // tasks
  // ************
  task automatic hang;
    fail_count++;
    $display("CHECK FAILED t=%0t no answer", $time);
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) hang;
    check_word(32'(bresp), 32'(RESP_OKAY));
    bready <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) hang;
    check_word(rdata, exp);
    check_word(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] s);
    int n = 0;
    @(posedge aclk);
    aresetn <= 1'b0;
    mode_strap <= s;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    while (strap_done !== 1'b1 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 50) hang;
    repeat (3) @(posedge aclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ************
  // tests
  // ************
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hF;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    mode_strap = 3'h4;
    do_reset(3'h4);
    rd(ADDR_BC, 32'h4, RESP_OKAY);
    rd(ADDR_MODE, 32'h40, RESP_OKAY);
    rd(ADDR_VCMAP, VCMAP_RST, RESP_OKAY);
    rd(ADDR_RAWHDR, RAWHDR_RST, RESP_OKAY);
    rd(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    rd(12'h100, 32'h0, RESP_SLVERR);
    $display("test reset values done");
    wr(ADDR_VCMAP, 32'hE4E4_1BE4);
    u_serializer_model.send('{2'h1, 2'h0, 6'h2A});
    @(posedge aclk);
    check_word(32'(hdr_out_valid), 32'h1);
    check_word(32'(hdr_out), 32'({2'h1, 2'h3, 6'h2A}));
    $display("test remap done");
    wr(ADDR_BC, 32'h2);
    rd(ADDR_BC, 32'h2, RESP_OKAY);
    check_word(32'(line_rate), 32'({SRC_SER_CLK, 8'h50, 2'h1, 3'h2, 2'h1}));
    wr(ADDR_CTRL, 32'h12);
    check_word(32'(lane_count), 32'h1);
    check_word(32'(line_rate), 32'({SRC_SER_CLK, 8'h50, 2'h1, 3'h1, 2'h1}));
    $display("test nonsync done");
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_MODE, 32'(m));
      check_word(32'(rx_mode), 32'(m));
      check_word(32'(frame_bits), 32'h1C);
      check_word(32'(back_channel_rate), 32'h0);
      check_word(32'(line_rate), 32'({SRC_PIXEL, ln[m-1], ld[m-1], pn[m-1], pd[m-1]}));
      check_word(32'(pixel_bits), 32'(px[m-1]));
      rd(ADDR_MODE, 32'h44 | 32'(m), RESP_OKAY);
    end
    rd(ADDR_BC, 32'h0, RESP_OKAY);
    wr(ADDR_RAWHDR, 32'h03AB_0100);
    u_serializer_model.send('{2'h2, 2'h1, 6'h05});
    @(posedge aclk);
    check_word(32'(hdr_out), 32'({2'h2, 2'h3, 6'h2A}));
    wr(ADDR_CTRL, 32'h13);
    check_word(32'(pixel_bits), 32'(PIX_8));
    $display("test raw modes done");
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_BC, 32'h4);
    check_word(32'(frame_bits), 32'h28);
    check_word(32'(line_rate), 32'({SRC_REF, 8'hA0, 2'h1, 3'h4, 2'h1}));
    $display("test sync done");
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      check_word(32'(rx_mode), 32'(s % 4));
    end
    $display("test straps done");
    // enable low must freeze the header path
    ce <= 1'b0;
    u_serializer_model.send('{2'h3, 2'h2, 6'h11});
    @(posedge aclk);
    check_word(32'(hdr_out_valid), 32'h0);
    ce <= 1'b1;
    $display("test enable done");
    give_verdict;
  end
  initial begin
    #100000;
    hang;
    give_verdict;
  end
endmodule

// File: hw/hub_mode_pkg.sv
package hub_mode_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] BC_INDEX = 12'h058;
  localparam logic [11:0] MODE_INDEX = 12'h06D;
  localparam logic [11:0] ADDR_BC = {BC_INDEX[9:0], 2'b00};
  localparam logic [11:0] ADDR_MODE = {MODE_INDEX[9:0], 2'b00};
  localparam logic [11:0] ADDR_VCMAP = 12'h000;
  localparam logic [11:0] ADDR_RAWHDR = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BC_SEL_LSB = 0;
  localparam int MODE_LSB = 0;
  localparam int MODE_OVR_BIT = 2;
  localparam int MODE_STRAP_LSB = 4;
  localparam int ST_PCLK_LSB = 0;
  localparam int ST_FRAME_LSB = 8;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_BC_LSB = 20;
  localparam int ST_SRC_LSB = 24;
  localparam int CTRL_RAW8_BIT = 0;
  localparam int CTRL_PCLK1X_BIT = 1;
  localparam int CTRL_LANES_LSB = 4;

  // ************************************************************
  // codes and reset values
  // ************************************************************
  localparam logic [2:0] BC_2M5 = 3'h0;
  localparam logic [2:0] BC_10M = 3'h2;
  localparam logic [2:0] BC_50M = 3'h4;
  localparam logic [2:0] BC_RST = BC_50M;
  localparam logic [31:0] VCMAP_RST = 32'hE4E4_E4E4;
  localparam logic [31:0] RAWHDR_RST = 32'h0302_0100;
  localparam logic [31:0] CTRL_RST = 32'h0000_0030;
  localparam logic [5:0] FRAME_PACKET = 6'h28;
  localparam logic [5:0] FRAME_RAW = 6'h1C;
  localparam logic [3:0] PIX_8 = 4'h8;
  localparam logic [3:0] PIX_10 = 4'hA;
  localparam logic [3:0] PIX_12 = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // timing counts
  // ************************************************************
  localparam logic [3:0] REF_WINDOW = 4'h8;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_PACKET = 2'b00,
    MODE_RAW12_LOW_FREQ = 2'b01,
    MODE_RAW12_HIGH_FREQ = 2'b10,
    MODE_RAW10 = 2'b11
  } rx_mode_type;

  typedef enum logic [1:0] {
    SRC_REF = 2'b00,
    SRC_SER_CLK = 2'b01,
    SRC_PIXEL = 2'b10
  } timing_src_type;

  typedef struct packed {
    timing_src_type src;
    logic [7:0] line_num;
    logic [1:0] line_den;
    logic [2:0] pclk_num;
    logic [1:0] pclk_den;
  } rate_type;

  typedef struct packed {
    logic [1:0] port;
    logic [1:0] vc;
    logic [5:0] dt;
  } hdr_type;

endpackage

// File: hw/hub_rx_mode_rate_config.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// R1: packetised mode uses 40-bit forward frames with video, control and framing data
// R2: raw pixel mode uses 28-bit forward frames at a lower line rate
// R3: synchronous packetised: line 160x ref, parallel 4x ref, back channel 2x ref
// R4: non-synchronous packetised: line 80x serializer clock, parallel 2x or 1x
// R5: non-synchronous packetised mode needs the 10 Mbps back-channel rate
// R6: forward line rate independent of output rate and of output lane count
// R7: packetised mode remaps incoming virtual channels per receive port
// R8: output streams carry a unique virtual channel in each header
// R9: raw mode accepts 8, 10 or 12 bit pixels, matching output type
// R10: raw mode inserts programmable per-port virtual channel and data type
// R11: raw12 high frequency: 12+2 bits, pixel 37.5-100 MHz, line pclk*2/3*28
// R12: raw12 low frequency: 12+2 bits, pixel 25-50 MHz, line pclk*28
// R13: raw10: 10+2 bits, pixel 50-100 MHz, line pclk/2*28
// R14: raw10 sender toggles syncs at most once per 10 pixel clocks
// R15: all raw modes run the back channel at 2.5 Mbps
// R16: packetised mode back channel defaults to 50 Mbps
// R17: writing 010 to back-channel select picks 10 Mbps
// R18: strap codes 0/4 packetised, 1/5 raw12 low freq, 2/6 raw12 high freq, 3/7 raw10
// R19: receive mode readable and overridable through mode register bits 1:0
// R20: packetised ports support line rates up to 4.16 Gbps
// R21: one output port with up to four lanes at 1.6 Gbps
// R22: control channel runs continuously, independent of video blanking
// R23: mode encoding is ours; a written mode overrides the strap until reset
module hub_rx_mode_rate_config
  import hub_mode_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic [2:0] mode_strap,
  input wire logic ref_clock_in,
  input wire logic recovered_parallel_clock,
  // incoming packet headers
  input wire hdr_type hdr_in,
  input wire logic hdr_in_valid,
  // outgoing packet headers
  output hdr_type hdr_out,
  output logic hdr_out_valid,
  // configuration results
  output rx_mode_type rx_mode,
  output logic strap_done,
  output logic [5:0] frame_bits,
  output logic [2:0] back_channel_rate,
  output rate_type line_rate,
  output logic [3:0] pixel_bits,
  output logic [1:0] lane_count
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_raw(input rx_mode_type m);
    return m != MODE_PACKET;
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] strap_sync;
  logic ref_rise;
  logic pclk_rise;

  pin_sync #(.WIDTH(3)) strap_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(mode_strap),
    .level(strap_sync),
    .rise()
  );

  pin_sync #(.WIDTH(1)) ref_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(ref_clock_in),
    .level(),
    .rise(ref_rise)
  );

  pin_sync #(.WIDTH(1)) pclk_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin(recovered_parallel_clock),
    .level(),
    .rise(pclk_rise)
  );

  // ************************************************************
  // strap capture
  // ************************************************************
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CAPT = 2'b01,
    ST_RUN = 2'b10
  } strap_state_type;

  strap_state_type state_q;
  strap_state_type state_d;
  logic [2:0] settle_q;
  logic [2:0] strap_q;

  // strap is caught some cycles after release, once the synchroniser has filled
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (settle_q == STRAP_SETTLE) begin
          state_d = ST_CAPT;
        end
      end
      ST_CAPT: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_WAIT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_WAIT;
      settle_q <= '0;
      strap_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == ST_WAIT) begin
        settle_q <= settle_q + 3'h1;
      end
      if (state_q == ST_CAPT) begin
        strap_q <= strap_sync;
      end
    end
  end

  // ************************************************************
  // axi4-lite write path
  // ************************************************************
  logic aw_full_q;
  logic w_full_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire wr_go = aw_full_q & w_full_q & ~bvalid_q;
  wire b_done = bvalid_q & bready;
  wire wr_bc = wr_go & (aw_addr_q == ADDR_BC);
  wire wr_mode = wr_go & (aw_addr_q == ADDR_MODE);
  wire wr_vcmap = wr_go & (aw_addr_q == ADDR_VCMAP);
  wire wr_rawhdr = wr_go & (aw_addr_q == ADDR_RAWHDR);
  wire wr_ctrl = wr_go & (aw_addr_q == ADDR_CTRL);
  wire wr_ro = wr_go & (aw_addr_q == ADDR_STATUS);
  wire wr_hit = wr_bc | wr_mode | wr_vcmap | wr_rawhdr | wr_ctrl | wr_ro;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {awaddr[11:2], 2'b00};
        awready_q <= 1'b0;
      end else if (!aw_full_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready_q <= 1'b0;
      end else if (!w_full_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [2:0] bc_sel_q;
  logic mode_ovr_q;
  rx_mode_type mode_wr_q;
  logic [31:0] vcmap_q;
  logic [31:0] rawhdr_q;
  logic [31:0] ctrl_q;
  logic [31:0] bc_new;
  logic [31:0] mode_new;

  assign bc_new = merge({29'h0, bc_sel_q}, w_data_q, w_strb_q);
  assign mode_new = merge({30'h0, mode_wr_q}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_sel_q <= BC_RST; // R16
      mode_ovr_q <= 1'b0;
      mode_wr_q <= MODE_PACKET;
      vcmap_q <= VCMAP_RST;
      rawhdr_q <= RAWHDR_RST;
      ctrl_q <= CTRL_RST;
    end else if (ce) begin
      if (wr_bc) begin
        bc_sel_q <= bc_new[BC_SEL_LSB +: 3]; // R17
      end
      if (wr_mode && w_strb_q[0]) begin
        mode_ovr_q <= 1'b1; // R23
        mode_wr_q <= rx_mode_type'(mode_new[MODE_LSB +: 2]); // R19
      end
      if (wr_vcmap) begin
        vcmap_q <= merge(vcmap_q, w_data_q, w_strb_q);
      end
      if (wr_rawhdr) begin
        rawhdr_q <= merge(rawhdr_q, w_data_q, w_strb_q);
      end
      if (wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
      end
    end
  end

  // ************************************************************
  // effective mode and rates
  // ************************************************************
  rx_mode_type mode_eff;
  logic [2:0] bc_eff;
  logic nonsync;
  rate_type rate_d;
  logic [3:0] pix_d;

  // upper strap bit only selects the resistor band, never the mode
  assign mode_eff = mode_ovr_q ? mode_wr_q : rx_mode_type'(strap_q[1:0]); // R18 R23
  // rate never depends on stream activity, so control runs through blanking
  assign bc_eff = is_raw(mode_eff) ? BC_2M5 : bc_sel_q; // R15 R22
  assign nonsync = ~is_raw(mode_eff) & (bc_sel_q == BC_10M); // R5

  // line rate is tied to the forward timing source, not the output lanes
  always_comb begin
    rate_d = '0; // R6
    case (mode_eff)
      MODE_PACKET: begin
        if (nonsync) begin
          rate_d.src = SRC_SER_CLK; // R4
          rate_d.line_num = 8'h50;
          rate_d.line_den = 2'h1;
          rate_d.pclk_num = ctrl_q[CTRL_PCLK1X_BIT] ? 3'h1 : 3'h2;
          rate_d.pclk_den = 2'h1;
        end else begin
          rate_d.src = SRC_REF; // R3 R20
          rate_d.line_num = 8'hA0;
          rate_d.line_den = 2'h1;
          rate_d.pclk_num = 3'h4;
          rate_d.pclk_den = 2'h1;
        end
      end
      MODE_RAW12_LOW_FREQ: begin
        rate_d.src = SRC_PIXEL; // R12
        rate_d.line_num = 8'h1C;
        rate_d.line_den = 2'h1;
        rate_d.pclk_num = 3'h1;
        rate_d.pclk_den = 2'h1;
      end
      MODE_RAW12_HIGH_FREQ: begin
        rate_d.src = SRC_PIXEL; // R11
        rate_d.line_num = 8'h38;
        rate_d.line_den = 2'h3;
        rate_d.pclk_num = 3'h2;
        rate_d.pclk_den = 2'h3;
      end
      MODE_RAW10: begin
        rate_d.src = SRC_PIXEL; // R13
        rate_d.line_num = 8'h0E;
        rate_d.line_den = 2'h1;
        rate_d.pclk_num = 3'h1;
        rate_d.pclk_den = 2'h2;
      end
      default: rate_d = '0;
    endcase
  end

  // raw8 rides in the 12-bit or 10-bit carriers
  always_comb begin
    pix_d = '0;
    if (is_raw(mode_eff)) begin
      if (ctrl_q[CTRL_RAW8_BIT]) begin
        pix_d = PIX_8; // R9
      end else if (mode_eff == MODE_RAW10) begin
        pix_d = PIX_10; // R9
      end else begin
        pix_d = PIX_12; // R9
      end
    end
  end

  // ************************************************************
  // parallel clock measurement
  // ************************************************************
  logic [3:0] ref_cnt_q;
  logic [6:0] pclk_cnt_q;
  logic [6:0] pclk_meas_q;
  wire win_end = ref_rise & (ref_cnt_q == REF_WINDOW - 4'h1);
  wire [6:0] pclk_next = pclk_cnt_q + {6'h0, pclk_rise & ~(&pclk_cnt_q)};

  // edges are counted per window of reference edges; at 4x the count is 32
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_q <= '0;
      pclk_cnt_q <= '0;
      pclk_meas_q <= '0;
    end else if (ce) begin
      if (win_end) begin
        ref_cnt_q <= '0;
        pclk_cnt_q <= '0;
        pclk_meas_q <= pclk_next;
      end else begin
        pclk_cnt_q <= pclk_next;
        if (ref_rise) begin
          ref_cnt_q <= ref_cnt_q + 4'h1;
        end
      end
    end
  end

  // ************************************************************
  // header rewrite
  // ************************************************************
  hdr_type hdr_d;
  logic [7:0] port_raw;
  logic [7:0] port_map;

  assign port_raw = rawhdr_q[{hdr_in.port, 3'b000} +: 8];
  assign port_map = vcmap_q[{hdr_in.port, 3'b000} +: 8];

  always_comb begin
    hdr_d = hdr_in;
    if (is_raw(mode_eff)) begin
      hdr_d.vc = port_raw[1:0]; // R10
      hdr_d.dt = port_raw[7:2]; // R10
    end else begin
      hdr_d.vc = port_map[{hdr_in.vc, 1'b0} +: 2]; // R7
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [31:0] status_word;
  wire [11:0] rd_addr = {araddr[11:2], 2'b00};
  wire ar_take = arvalid & arready_q;

  always_comb begin
    status_word = '0;
    status_word[ST_PCLK_LSB +: 7] = pclk_meas_q;
    status_word[ST_FRAME_LSB +: 6] = frame_bits;
    status_word[ST_MODE_LSB +: 2] = mode_eff;
    status_word[ST_BC_LSB +: 3] = bc_eff;
    status_word[ST_SRC_LSB +: 2] = rate_d.src;
  end

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (rd_addr)
      ADDR_BC: rd_mux[BC_SEL_LSB +: 3] = bc_eff;
      ADDR_MODE: begin
        rd_mux[MODE_LSB +: 2] = mode_eff; // R19
        rd_mux[MODE_OVR_BIT] = mode_ovr_q;
        rd_mux[MODE_STRAP_LSB +: 3] = strap_q;
      end
      ADDR_VCMAP: rd_mux = vcmap_q;
      ADDR_RAWHDR: rd_mux = rawhdr_q;
      ADDR_STATUS: rd_mux = status_word;
      ADDR_CTRL: rd_mux = ctrl_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  hdr_type hdr_q;
  logic hdr_valid_q;
  rx_mode_type mode_q;
  logic [5:0] frame_q;
  logic [2:0] bc_q;
  rate_type rate_q;
  logic [3:0] pix_q;
  logic [1:0] lanes_q;
  logic done_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_q <= '0;
      hdr_valid_q <= 1'b0;
      mode_q <= MODE_PACKET;
      frame_q <= FRAME_PACKET;
      bc_q <= BC_RST;
      rate_q <= '0;
      pix_q <= '0;
      lanes_q <= CTRL_RST[CTRL_LANES_LSB +: 2];
      done_q <= 1'b0;
    end else if (ce) begin
      hdr_q <= hdr_d; // R8
      hdr_valid_q <= hdr_in_valid & (state_q == ST_RUN);
      mode_q <= mode_eff;
      frame_q <= is_raw(mode_eff) ? FRAME_RAW : FRAME_PACKET; // R1 R2
      bc_q <= bc_eff;
      rate_q <= rate_d;
      pix_q <= pix_d;
      lanes_q <= ctrl_q[CTRL_LANES_LSB +: 2]; // R21
      done_q <= state_q == ST_RUN;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign hdr_out = hdr_q;
  assign hdr_out_valid = hdr_valid_q;
  assign rx_mode = mode_q;
  assign frame_bits = frame_q;
  assign back_channel_rate = bc_q;
  assign line_rate = rate_q;
  assign pixel_bits = pix_q;
  assign lane_count = lanes_q;
  assign strap_done = done_q;

endmodule

// File: hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pin side
  input wire logic [WIDTH-1:0] pin,
  // synchronised side
  output logic [WIDTH-1:0] level,
  output logic rise
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic last_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q[0];
    end
  end

  assign level = sync_q;
  assign rise = ce & sync_q[0] & ~last_q;

endmodule
